// file: gate_fault_pkg.sv
// Constants, types and timing counts shared by the gate driver fault manager
// Function
// - Low supply undervoltage pulls fault line, disables both
// - Low supply undervoltage not latched, releases on recovery
// - Floating undervoltage disables high side only, silently
// - High side relocks until fresh high input edge
// - Desaturation pulses shorter than filter time ignored
// - Desaturation blanked after turn-on, then faults
// - Qualified desaturation starts soft shutdown on that side
// - Sync line held low during whole soft shutdown
// - Soft shutdown end without fault clear pulls fault line, hard shutdown
// - Outputs latched low until fault clear
// - Soft shutdown masks undervoltage and external shutdown
// - Desaturation monitored only while that output is on
// - Sync line is shared active-low wired network
// - Low sync line freezes outputs, ignores inputs
// - Desaturation detection overrides freeze
// - Low fault line from anyone forces hard shutdown
// - Latched fault line released only by fault clear
// - External fault low unlatched, fault clear ineffective
// - Outputs follow inputs with deadtime, both high means off
`default_nettype none
package gate_fault_pkg;
	// ==========================================================
	// Clock and times
	localparam int CLK_MHZ = 125;
	localparam int NS_PER_US = 1000;
	localparam int BLANK_NS = 3000;
	localparam int SOFT_NS = 9250;
	localparam int DEAD_NS = 330;
	localparam int FILT_NS = 250;
	// Least times round up, longest times round down
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int SOFT_CYC = (SOFT_NS * CLK_MHZ) / NS_PER_US;
	localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int FILT_CYC = (FILT_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int CNT_W = 11;
	// ==========================================================
	// Register port
	localparam int REG_AW = 2;
	localparam int REG_DW = 8;
	localparam logic [REG_AW-1:0] ADDR_CTRL = 2'h0;
	localparam logic [REG_AW-1:0] ADDR_STAT = 2'h1;
	localparam logic [REG_DW-1:0] CTRL_RESET = 8'h2a;
	localparam int ST_LOW_ON = 0;
	localparam int ST_HIGH_ON = 1;
	localparam int ST_FAULT_DRV = 2;
	localparam int ST_SYNC_DRV = 3;
	localparam int ST_HIGH_LOCK = 4;
	localparam int ST_STATE = 5;
	// ==========================================================
	// Synchroniser lanes
	localparam int SY_W = 7;
	localparam int SY_SYNC = 0;
	localparam int SY_FAULT = 1;
	localparam int SY_CLEAR = 2;
	localparam int SY_HDESAT = 3;
	localparam int SY_LDESAT = 4;
	localparam int SY_LOWUV = 5;
	localparam int SY_FLOATUV = 6;
	localparam logic [SY_W-1:0] SY_INIT = 7'h03;
	// ==========================================================
	// Fault sequencer states
	typedef enum logic [2:0] {
		ST_RUN = 3'h1,
		ST_SOFT = 3'h2,
		ST_LATCH = 3'h4
	} fault_state_t;
endpackage
`default_nettype wire

// file: sync_pair.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sync_pair #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Levels
	input wire logic [W-1:0] async,
	output var logic [W-1:0] synced
);
	logic [W-1:0] stage;

	// First stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stage <= INIT;
			synced <= INIT;
		end else if (ce) begin
			stage <= async;
			synced <= stage;
		end
	end
endmodule
`default_nettype wire

// file: desat_qualifier.sv
// Desaturation blanking and noise filter for one output side
`timescale 1ns/1ps
`default_nettype none
module desat_qualifier #(
	parameter int BLANK = 375,
	parameter int FILT = 32,
	parameter int CW = 11
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Side status
	input wire logic outOn,
	input wire logic desat,
	output var logic qualified
);
	logic [CW-1:0] blankCnt;
	logic [CW-1:0] filtCnt;
	logic blanked;

	assign blanked = (blankCnt == CW'(BLANK));

	// Blanking after turn-on, cleared whenever the output is off
	always_ff @(posedge core_clk) begin
		if (!rst_n || (ce && !outOn)) begin
			blankCnt <= '0;
		end else if (ce && !blanked) begin
			blankCnt <= blankCnt + 1'b1;
		end
	end

	// Filter: flag must stand FILT cycles unbroken
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			filtCnt <= '0;
			qualified <= 1'b0;
		end else if (ce) begin
			if (!outOn || !blanked || !desat) begin
				filtCnt <= '0;
				qualified <= 1'b0;
			end else if (filtCnt != CW'(FILT - 1)) begin
				filtCnt <= filtCnt + 1'b1;
				qualified <= 1'b0;
			end else begin
				qualified <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge core_clk iff ce); endclocking
	default disable iff (!rst_n);

	a_blank_masks: assert property (!blanked |=> !qualified)
		else $error("desat qualified during blanking");
	a_short_ignored: assert property (!desat |=> !qualified)
		else $error("desat qualified without stable flag");
endmodule
`default_nettype wire

// file: gate_fault_manager.sv
// Fault manager of a half-bridge gate driver
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gate_fault_manager #(
	parameter int BLANK_CYCLES = gate_fault_pkg::BLANK_CYC,
	parameter int FILT_CYCLES = gate_fault_pkg::FILT_CYC,
	parameter int SOFT_CYCLES = gate_fault_pkg::SOFT_CYC
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Controller inputs
	input wire logic highIn,
	input wire logic lowIn,
	input wire logic faultClearInput,
	// Analog comparator flags
	input wire logic highDesatSense,
	input wire logic lowDesatSense,
	input wire logic lowSupplyUv,
	input wire logic floatSupplyUv,
	// Sync freeze line, active low wired
	input wire logic syncFreezeLineIn,
	output logic syncFreezeLineOut,
	output var logic syncFreezeLineOe_n,
	// Fault shutdown line, active low wired
	input wire logic faultShutdownLineIn,
	output logic faultShutdownLineOut,
	output var logic faultShutdownLineOe_n,
	// High side output stage
	output var logic highPullUp,
	output var logic highPullDown,
	output var logic highSoftPulldown,
	// Low side output stage
	output var logic lowPullUp,
	output var logic lowPullDown,
	output var logic lowSoftPulldown,
	// Register port
	input wire logic [gate_fault_pkg::REG_AW-1:0] regAddr,
	input wire logic [gate_fault_pkg::REG_DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output var logic [gate_fault_pkg::REG_DW-1:0] regRdData
);
	import gate_fault_pkg::*;

	// ==========================================================
	// Declarations
	fault_state_t state, next_state;
	logic [SY_W-1:0] syRaw, sy;
	logic highQual, lowQual, highOn, lowOn;
	logic next_highOn, next_lowOn, softHigh;
	logic [CNT_W-1:0] softCnt;
	logic [REG_DW-1:0] highDt, lowDt, dtCfg;
	logic highLock, highInPrev, highRise;
	logic drvFault, drvSync, next_drvFault;
	logic [1:0] faultEcho;
	logic faultExt, freeze, clearReq, lowUv, floatUv;
	logic hardOff, inSoft, softEnd, highReq, lowReq;

	// ==========================================================
	// Functions
	function automatic logic [REG_DW-1:0] dtStep(input logic [REG_DW-1:0] cnt,
			input logic req, input logic otherOn, input logic [REG_DW-1:0] lim);
		logic [REG_DW-1:0] res;
		res = cnt;
		if (!req || otherOn) begin
			res = '0;
		end else if (cnt != lim) begin
			res = cnt + 1'b1;
		end
		return res;
	endfunction

	function automatic logic dtDone(input logic [REG_DW-1:0] cnt,
			input logic [REG_DW-1:0] lim);
		return cnt == lim;
	endfunction

	// ==========================================================
	// Input synchronisation
	assign syRaw[SY_SYNC] = syncFreezeLineIn;
	assign syRaw[SY_FAULT] = faultShutdownLineIn;
	assign syRaw[SY_CLEAR] = faultClearInput;
	assign syRaw[SY_HDESAT] = highDesatSense;
	assign syRaw[SY_LDESAT] = lowDesatSense;
	assign syRaw[SY_LOWUV] = lowSupplyUv;
	assign syRaw[SY_FLOATUV] = floatSupplyUv;

	sync_pair #(.W(SY_W), .INIT(SY_INIT)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.async(syRaw),
		.synced(sy)
	);

	assign clearReq = sy[SY_CLEAR];
	assign lowUv = sy[SY_LOWUV];
	assign floatUv = sy[SY_FLOATUV];
	assign freeze = !sy[SY_SYNC];
	// Own drive returns through the synchroniser two cycles later
	assign faultExt = !sy[SY_FAULT] && !faultEcho[1] && !drvFault;

	// ==========================================================
	// Desaturation qualifiers, one per side
	desat_qualifier #(
		.BLANK(BLANK_CYCLES),
		.FILT(FILT_CYCLES),
		.CW(CNT_W)
	) u_high_desat (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.outOn(highOn),
		.desat(sy[SY_HDESAT]),
		.qualified(highQual)
	);

	desat_qualifier #(
		.BLANK(BLANK_CYCLES),
		.FILT(FILT_CYCLES),
		.CW(CNT_W)
	) u_low_desat (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.outOn(lowOn),
		.desat(sy[SY_LDESAT]),
		.qualified(lowQual)
	);

	// ==========================================================
	// Fault sequencer
	assign inSoft = (state == ST_SOFT);
	assign softEnd = inSoft && (softCnt == CNT_W'(SOFT_CYCLES - 1));

	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (highQual || lowQual) begin
					next_state = ST_SOFT;
				end
			end
			ST_SOFT: begin
				if (softEnd) begin
					next_state = clearReq ? ST_RUN : ST_LATCH;
				end
			end
			ST_LATCH: begin
				if (clearReq) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_LATCH;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_RUN;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Soft shutdown timer and side
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			softCnt <= '0;
			softHigh <= 1'b0;
		end else if (ce) begin
			if (state == ST_RUN) begin
				softCnt <= '0;
				softHigh <= highQual;
			end else if (inSoft) begin
				softCnt <= softCnt + 1'b1;
			end
		end
	end

	// ==========================================================
	// Shared line drive
	// Undervoltage and external shutdown masked while soft
	assign hardOff = !inSoft && (faultExt || lowUv || state == ST_LATCH);
	assign next_drvFault = (next_state == ST_LATCH) || (lowUv && next_state != ST_SOFT);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			drvFault <= 1'b0;
			drvSync <= 1'b0;
			faultEcho <= '0;
		end else if (ce) begin
			drvFault <= next_drvFault;
			drvSync <= (next_state == ST_SOFT);
			faultEcho <= {faultEcho[0], drvFault};
		end
	end

	assign syncFreezeLineOut = 1'b0;
	assign faultShutdownLineOut = 1'b0;
	assign syncFreezeLineOe_n = !drvSync;
	assign faultShutdownLineOe_n = !drvFault;

	// ==========================================================
	// Floating supply lock
	assign highRise = highIn && !highInPrev;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			highLock <= 1'b0;
			highInPrev <= 1'b0;
		end else if (ce) begin
			highInPrev <= highIn;
			if (floatUv) begin
				highLock <= 1'b1;
			end else if (highRise) begin
				highLock <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Deadtime and output decisions
	assign highReq = highIn && !lowIn;
	assign lowReq = lowIn && !highIn;

	always_comb begin
		next_highOn = highOn;
		next_lowOn = lowOn;
		if (inSoft) begin
			if (softHigh) begin
				next_highOn = 1'b0;
			end else begin
				next_lowOn = 1'b0;
			end
		end else if (next_state == ST_SOFT || hardOff) begin
			next_highOn = 1'b0;
			next_lowOn = 1'b0;
		end else if (!freeze) begin
			next_highOn = highReq && dtDone(highDt, dtCfg) && !lowOn;
			next_lowOn = lowReq && dtDone(lowDt, dtCfg) && !highOn;
		end
		if (floatUv || highLock) begin
			next_highOn = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			highDt <= '0;
			lowDt <= '0;
		end else if (ce) begin
			highDt <= dtStep(highDt, highReq, lowOn, dtCfg);
			lowDt <= dtStep(lowDt, lowReq, highOn, dtCfg);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			highOn <= 1'b0;
			lowOn <= 1'b0;
			highPullUp <= 1'b0;
			highPullDown <= 1'b1;
			highSoftPulldown <= 1'b0;
			lowPullUp <= 1'b0;
			lowPullDown <= 1'b1;
			lowSoftPulldown <= 1'b0;
		end else if (ce) begin
			highOn <= next_highOn;
			lowOn <= next_lowOn;
			// Soft side stage: normal devices off, soft pull-down on
			highSoftPulldown <= (next_state == ST_SOFT) && (inSoft ? softHigh : highQual);
			lowSoftPulldown <= (next_state == ST_SOFT) && (inSoft ? !softHigh : !highQual);
			highPullUp <= next_highOn;
			lowPullUp <= next_lowOn;
			highPullDown <= !next_highOn &&
				!((next_state == ST_SOFT) && (inSoft ? softHigh : highQual));
			lowPullDown <= !next_lowOn &&
				!((next_state == ST_SOFT) && (inSoft ? !softHigh : !highQual));
		end
	end

	// ==========================================================
	// Register port
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dtCfg <= CTRL_RESET;
		end else if (ce && regWr && regAddr == ADDR_CTRL) begin
			dtCfg <= regWrData;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			regRdData <= '0;
		end else if (ce) begin
			regRdData <= '0;
			if (regRd && regAddr == ADDR_CTRL) begin
				regRdData <= dtCfg;
			end else if (regRd && regAddr == ADDR_STAT) begin
				regRdData[ST_LOW_ON] <= lowOn;
				regRdData[ST_HIGH_ON] <= highOn;
				regRdData[ST_FAULT_DRV] <= drvFault;
				regRdData[ST_SYNC_DRV] <= drvSync;
				regRdData[ST_HIGH_LOCK] <= highLock;
				regRdData[REG_DW-1:ST_STATE] <= state;
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk iff ce); endclocking
	default disable iff (!rst_n);

	sequence s_soft_start;
		(state == ST_RUN) && (highQual || lowQual);
	endsequence

	sequence s_soft_last;
		softEnd && !clearReq;
	endsequence

	a_uv_pulls_fault: assert property (lowUv && !inSoft && !highQual && !lowQual
			|=> drvFault && !highOn && !lowOn)
		else $error("low undervoltage did not shut down");
	a_uv_releases: assert property ((state == ST_RUN) && !lowUv |=> !drvFault)
		else $error("fault line held after undervoltage");
	a_float_high_only: assert property (floatUv && !lowUv && (state == ST_RUN)
			|=> !highOn && !drvFault)
		else $error("floating undervoltage misbehaved");
	a_lock_needs_edge: assert property (highLock && !highRise |=> !highOn)
		else $error("high side on without fresh edge");
	a_soft_entry: assert property (s_soft_start |=> inSoft && drvSync
			&& (highSoftPulldown || lowSoftPulldown))
		else $error("soft shutdown not entered");
	a_sync_held: assert property (inSoft && !softEnd |=> inSoft && drvSync)
		else $error("sync line released early");
	a_soft_to_latch: assert property (s_soft_last |=> drvFault
			&& !highOn && !lowOn ##1 !drvSync)
		else $error("no hard shutdown after soft");
	a_latch_hold: assert property ((state == ST_LATCH) && !clearReq
			|=> drvFault && !highOn && !lowOn)
		else $error("latched fault lost");
	a_soft_masks: assert property (inSoft && !softEnd |=> !drvFault)
		else $error("fault line during soft shutdown");
	a_ext_shutdown: assert property (faultExt && !inSoft |=> !highOn && !lowOn)
		else $error("external shutdown ignored");
	a_freeze_hold: assert property (freeze && (state == ST_RUN) && !hardOff
			&& !highQual && !lowQual && !floatUv && !highLock |=> $stable(highOn) && $stable(lowOn))
		else $error("outputs moved while frozen");
	a_anti_shoot: assert property (highIn && lowIn && (state == ST_RUN) && !freeze
			|=> !highOn && !lowOn)
		else $error("outputs on with both inputs high");
	a_no_overlap: assert property (!(highOn && lowOn))
		else $error("both outputs on");
endmodule
`default_nettype wire

// file: peer_line_model.sv
// Wired sync and fault networks seen through a peer driver and the controller
`timescale 1ns/1ps
`default_nettype none
module peer_line_model (
	// Clock
	input wire logic core_clk,
	// Pull requests of peer and controller
	input wire logic pullSync,
	input wire logic pullFault,
	// Device drives, low = pulling
	input wire logic syncOe_n,
	input wire logic faultOe_n,
	// Resolved line levels
	output logic syncLine,
	output logic faultLine
);
	logic peerSync = 1'b0;
	logic peerFault = 1'b0;
	// Far side changes its pulls only at a clock edge
	always_ff @(posedge core_clk) begin
		peerSync <= pullSync;
		peerFault <= pullFault;
	end
	// Pull-ups bring released lines back high
	assign syncLine = !(peerSync || !syncOe_n);
	assign faultLine = !(peerFault || !faultOe_n);
endmodule
`default_nettype wire

// file: test_gate_fault_manager.sv
// Self-checking bench of the gate driver fault manager
`timescale 1ns/1ps
`default_nettype none
module test_gate_fault_manager;
	import gate_fault_pkg::*;
	localparam int BL = 8;
	localparam int FI = 4;
	localparam int SO = 20;
	localparam logic [7:0] DT = 8'h03;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic hIn = 1'b0, lIn = 1'b0, clr = 1'b0, hDs = 1'b0, lDs = 1'b0, lUv = 1'b0, fUv = 1'b0;
	logic pullSync = 1'b0, pullFault = 1'b0;
	logic syncLine, faultLine, syncOe_n, faultOe_n;
	logic hUp, hDn, hSoft, lUp, lDn, lSoft;
	logic syncOut, faultOut, hB, lB;
	logic [REG_AW-1:0] regAddr = '0;
	logic [REG_DW-1:0] regWrData = '0;
	logic regWr = 1'b0, regRd = 1'b0;
	logic [REG_DW-1:0] regRdData;
	logic [31:0] seed = 32'hc7c7;
	logic [7:0] d;
	wire logic [7:0] outs = {2'h0, hUp, hDn, hSoft, lUp, lDn, lSoft};
	int n_fail = 0;
	int n_tests = 0;
	int cycles = 0;
	int k, n;

	always #4 core_clk = ~core_clk;

	gate_fault_manager #(.BLANK_CYCLES(BL), .FILT_CYCLES(FI), .SOFT_CYCLES(SO)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .highIn(hIn), .lowIn(lIn),
		.faultClearInput(clr), .highDesatSense(hDs), .lowDesatSense(lDs),
		.lowSupplyUv(lUv), .floatSupplyUv(fUv), .syncFreezeLineIn(syncLine),
		.syncFreezeLineOut(syncOut), .syncFreezeLineOe_n(syncOe_n),
		.faultShutdownLineIn(faultLine), .faultShutdownLineOut(faultOut),
		.faultShutdownLineOe_n(faultOe_n), .highPullUp(hUp),
		.highPullDown(hDn), .highSoftPulldown(hSoft), .lowPullUp(lUp), .lowPullDown(lDn),
		.lowSoftPulldown(lSoft), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData));

	peer_line_model far (.core_clk(core_clk), .pullSync(pullSync), .pullFault(pullFault),
		.syncOe_n(syncOe_n), .faultOe_n(faultOe_n), .syncLine(syncLine), .faultLine(faultLine));

	// ==========================================================
	// Expectations and helpers
	function automatic logic [7:0] drive(input logic h, input logic l);
		return {2'h0, h, !h, 1'b0, l, !l, 1'b0};
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] v);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		cyc(1);
		regWr <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] v);
		regAddr <= a;
		regRd <= 1'b1;
		cyc(1);
		regRd <= 1'b0;
		cyc(1);
		v = regRdData;
	endtask
	task automatic clearFault();
		clr <= 1'b1;
		cyc(3);
		clr <= 1'b0;
		cyc(DT + 8);
	endtask
	task automatic report_and_stop();
		if (n_fail == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		cyc(20);
		rst_n <= 1'b1;
		cyc(1);
		chk("reset outs", outs, drive(0, 0));
		chk("line data", {6'h0, syncOut, faultOut}, 8'h00);
		rd(ADDR_CTRL, d);
		chk("ctrl reset", d, CTRL_RESET);
		rd(2'h2, d);
		chk("unmapped", d, 8'h00);
		wr(2'h3, 8'hff);
		wr(ADDR_CTRL, DT);
		rd(ADDR_CTRL, d);
		chk("ctrl", d, DT);
		// Deadtime holds a fresh turn-on back
		hIn <= 1'b1;
		cyc(2);
		chk("deadtime", outs, drive(0, 0));
		for (k = 0; k < 40; k++) begin
			seed = lfsr(seed);
			hB = seed[0] | (k == 39);
			lB = seed[1] | (k == 39);
			hIn <= hB;
			lIn <= lB;
			cyc(DT + 8);
			chk("follow", outs, drive(hB & !lB, lB & !hB));
		end
		hIn <= 1'b1;
		lIn <= 1'b0;
		cyc(DT + 8);
		rd(ADDR_STAT, d);
		chk("status", d, 8'h22);
		// Low supply undervoltage
		lUv <= 1'b1;
		cyc(5);
		chk("uv fault", 8'(faultOe_n), 8'h00);
		chk("uv outs", outs, drive(0, 0));
		lUv <= 1'b0;
		cyc(5);
		chk("uv release", 8'(faultOe_n), 8'h01);
		cyc(DT + 8);
		chk("uv resume", outs, drive(1, 0));
		// Floating supply undervoltage and high side lock
		fUv <= 1'b1;
		cyc(5);
		chk("fuv outs", outs, drive(0, 0));
		chk("fuv lines", {6'h0, faultOe_n, syncOe_n}, 8'h03);
		hIn <= 1'b0;
		lIn <= 1'b1;
		cyc(DT + 8);
		chk("fuv low", outs, drive(0, 1));
		lIn <= 1'b0;
		hIn <= 1'b1;
		cyc(DT + 8);
		fUv <= 1'b0;
		cyc(DT + 8);
		chk("lock", outs, drive(0, 0));
		hIn <= 1'b0;
		cyc(2);
		hIn <= 1'b1;
		cyc(DT + 8);
		chk("relock", outs, drive(1, 0));
		// Short desaturation glitch and desaturation on an off side
		hDs <= 1'b1;
		lDs <= 1'b1;
		cyc(FI - 2);
		hDs <= 1'b0;
		cyc(BL + FI + 10);
		chk("glitch", outs, drive(1, 0));
		lDs <= 1'b0;
		hIn <= 1'b0;
		cyc(DT + 8);
		// Desaturation from turn-on, blanking, soft shutdown
		hIn <= 1'b1;
		hDs <= 1'b1;
		for (k = 0; k < 30 && hUp !== 1'b1; k++) cyc(1);
		for (k = 0; k < BL; k++) begin
			cyc(1);
			chk("blank", 8'(hSoft), 8'h00);
		end
		for (k = 0; k < 30 && hSoft !== 1'b1; k++) cyc(1);
		chk("soft outs", outs, 8'h0a);
		chk("sync drive", 8'(syncOe_n), 8'h00);
		lUv <= 1'b1;
		cyc(6);
		chk("uv masked", 8'(faultOe_n), 8'h01);
		lUv <= 1'b0;
		n = 6;
		while (hSoft === 1'b1 && n < 99) begin
			cyc(1);
			n++;
		end
		chk("soft len", 8'(n >= SO && n <= SO + 1), 8'h01);
		cyc(2);
		chk("sync free", 8'(syncOe_n), 8'h01);
		chk("hard fault", 8'(faultOe_n), 8'h00);
		chk("hard outs", outs, drive(0, 0));
		hDs <= 1'b0;
		hIn <= 1'b0;
		lIn <= 1'b1;
		cyc(DT + 8);
		chk("latched", outs, drive(0, 0));
		chk("latched line", 8'(faultOe_n), 8'h00);
		clearFault();
		chk("cleared", 8'(faultOe_n), 8'h01);
		chk("cleared outs", outs, drive(0, 1));
		// Freeze by a peer, own desaturation still wins
		pullSync <= 1'b1;
		cyc(3);
		hIn <= 1'b1;
		lIn <= 1'b0;
		cyc(DT + 8);
		chk("freeze", outs, drive(0, 1));
		lDs <= 1'b1;
		for (k = 0; k < 30 && lSoft !== 1'b1; k++) cyc(1);
		chk("freeze desat", outs, 8'h11);
		pullSync <= 1'b0;
		lDs <= 1'b0;
		cyc(SO + 6);
		chk("low hard", 8'(faultOe_n), 8'h00);
		clearFault();
		chk("low clear", outs, drive(1, 0));
		// Shutdown commanded from outside
		pullFault <= 1'b1;
		cyc(5);
		chk("ext sd", outs, drive(0, 0));
		chk("ext own", 8'(faultOe_n), 8'h01);
		clearFault();
		chk("ext no clear", outs, drive(0, 0));
		pullFault <= 1'b0;
		cyc(DT + 10);
		chk("ext resume", outs, drive(1, 0));
		// Clear held through a soft shutdown leaves no latched fault
		clr <= 1'b1;
		hDs <= 1'b1;
		for (k = 0; k < 30 && hSoft !== 1'b1; k++) cyc(1);
		hDs <= 1'b0;
		cyc(SO + 6);
		chk("clear held", {6'h0, faultOe_n, hUp}, 8'h03);
		clr <= 1'b0;
		// Clock enable low freezes all state
		ce <= 1'b0;
		hIn <= 1'b0;
		cyc(6);
		chk("ce hold", outs, drive(1, 0));
		ce <= 1'b1;
		cyc(DT + 8);
		chk("ce run", outs, drive(0, 0));
		// Reset again in mid-run
		rst_n <= 1'b0;
		hIn <= 1'b1;
		cyc(4);
		rst_n <= 1'b1;
		cyc(1);
		chk("rerun outs", outs, drive(0, 0));
		chk("rerun lines", {6'h0, faultOe_n, syncOe_n}, 8'h03);
		rd(ADDR_CTRL, d);
		chk("rerun ctrl", d, CTRL_RESET);
		report_and_stop();
	end
endmodule
`default_nettype wire
